// ==== shared/vse_pkg.sv ====
package vse_pkg;

    // -------------------------------------------------------------------
    // Register offsets.
    // -------------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_VOUT_CMD = 8'h04;
    localparam logic [7:0] OFS_CAL_OFS = 8'h08;
    localparam logic [7:0] OFS_SCALE = 8'h0c;
    localparam logic [7:0] OFS_VOUT_MAX = 8'h10;
    localparam logic [7:0] OFS_MARGIN_HI = 8'h14;
    localparam logic [7:0] OFS_MARGIN_LO = 8'h18;
    localparam logic [7:0] OFS_SAMPLE_TIME = 8'h1c;
    localparam logic [7:0] OFS_COEF_LOAD = 8'h20;
    localparam logic [7:0] OFS_LIGHT_THR = 8'h24;
    localparam logic [7:0] OFS_STATUS = 8'h28;
    localparam logic [7:0] OFS_ERROR = 8'h2c;

    // -------------------------------------------------------------------
    // Field positions and reset values.
    // -------------------------------------------------------------------
    localparam int CTRL_OP_LSB = 0;
    localparam int CTRL_SUPPRESS = 2;
    localparam int CTRL_DYN = 3;
    localparam int COEF_GAIN_LSB = 0;
    localparam int COEF_BANK_LSB = 4;
    localparam logic [9:0] RST_VOUT_CMD = 10'h000;
    localparam logic [9:0] RST_VOUT_MAX = 10'h3ff;
    localparam logic [7:0] RST_SCALE = 8'hff;
    localparam logic [11:0] RST_SAMPLE_TIME = 12'h000;
    localparam logic [11:0] RST_LIGHT_THR = 12'h000;
    localparam logic [1:0] RST_GAIN = 2'h2;

    // -------------------------------------------------------------------
    // Widths and converter limits.
    // -------------------------------------------------------------------
    localparam int DAC_W = 10;
    localparam int SENSE_W = 12;
    localparam int ERR_W = 14;
    localparam int CODE_W = 6;
    localparam int NUM_BANKS = 3;
    localparam logic [5:0] CODE_MAX = 6'h1f;
    localparam logic [5:0] CODE_MIN = 6'h20;

    // -------------------------------------------------------------------
    // Slew timing: 0.156 V/ms is 156 mV/ms, one DAC step is 1 mV.
    // -------------------------------------------------------------------
    localparam int CLK_KHZ = 40000;
    localparam int SLEW_MV_PER_MS = 156;
    localparam int SLEW_CYCLES = CLK_KHZ / SLEW_MV_PER_MS;

    typedef enum logic [1:0] {
        VSE_OP_NOMINAL,
        VSE_OP_MARGIN_LOW,
        VSE_OP_MARGIN_HIGH,
        VSE_OP_SPARE
    } vse_op_e;

    typedef enum logic [1:0] {
        VSE_BANK_RAMP,
        VSE_BANK_REG,
        VSE_BANK_LIGHT,
        VSE_BANK_NONE
    } vse_bank_e;

endpackage

// ==== logic/vse_ref_target.sv ====
`timescale 1ns/10ps
`default_nettype none

module vse_ref_target (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic dyn_voltage_select_cfg,
    input wire logic [1:0] op_select,
    input wire logic [9:0] vid_dac_code,
    input wire logic [9:0] vout_command,
    input wire logic signed [9:0] vout_cal_offset,
    input wire logic [7:0] vout_scale_loop,
    input wire logic [9:0] vout_max,
    input wire logic [9:0] margin_high,
    input wire logic [9:0] margin_low,
    output logic [9:0] target_code
);

    logic [9:0] target_reg;
    logic [9:0] sel_v;
    logic signed [11:0] sum_v;
    logic [19:0] scaled_v;
    logic [9:0] clamp_v;

    // -------------------------------------------------------------------
    // Set-point selection, offset, scaling and ceiling.
    // -------------------------------------------------------------------
    always_comb begin
        case (vse_pkg::vse_op_e'(op_select))
            vse_pkg::VSE_OP_MARGIN_HIGH: sel_v = margin_high;
            vse_pkg::VSE_OP_MARGIN_LOW: sel_v = margin_low;
            default: sel_v = vout_command;
        endcase
        sum_v = $signed({2'b00, sel_v}) + 12'(vout_cal_offset);
        if (sum_v < 0) begin
            scaled_v = 20'h00000;
        end else begin
            scaled_v = 20'(sum_v[10:0]) * 20'(vout_scale_loop);
        end
        clamp_v = (scaled_v[19:8] > 12'(vout_max)) ? vout_max : scaled_v[17:8];
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            target_reg <= 10'h000;
        end else if (ce) begin
            target_reg <= dyn_voltage_select_cfg ? vid_dac_code : clamp_v;
        end
    end

    assign target_code = target_reg;

endmodule // vse_ref_target

`default_nettype wire

// ==== logic/vse_error_quantizer.sv ====
`timescale 1ns/10ps
`default_nettype none

module vse_error_quantizer (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic sample,
    input wire logic signed [13:0] error_mv,
    input wire logic [1:0] error_gain_code,
    output logic [5:0] code,
    output logic code_valid
);

    logic [5:0] code_reg;
    logic valid_reg;
    logic signed [13:0] shifted_v;
    logic [5:0] code_next;

    // -------------------------------------------------------------------
    // Step is 8, 4, 2 or 1 mV; out-of-range errors clamp.
    // -------------------------------------------------------------------
    always_comb begin
        shifted_v = error_mv >>> (2'd3 - error_gain_code);
        if (shifted_v > 14'sd31) begin
            code_next = vse_pkg::CODE_MAX;
        end else if (shifted_v < -14'sd32) begin
            code_next = vse_pkg::CODE_MIN;
        end else begin
            code_next = shifted_v[5:0];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            code_reg <= 6'h00;
            valid_reg <= 1'b0;
        end else if (ce) begin
            valid_reg <= sample;
            if (sample) begin
                code_reg <= code_next;
            end
        end
    end

    assign code = code_reg;
    assign code_valid = valid_reg;

endmodule // vse_error_quantizer

`default_nettype wire

// ==== logic/vse_setpoint_sense.sv ====
// Contract
// [RULE1] Dynamic_voltage_select_cfg picks fixed or dynamic set-point.
// [RULE2] Nominal reference from command, offset, scale, ceiling.
// [RULE3] Operation selects nominal, margin high, margin low.
// [RULE4] Suppress voltage faults at margins on request.
// [RULE5] Sample sense once per period at set time.
// [RULE6] Error is sense minus 10-bit DAC.
// [RULE7] Gain code gives 1x to 8x steps.
// [RULE8] Error range limited according to gain code.
// [RULE9] Host should prefer the 4x gain code.
// [RULE10] Gain stored with loaded coefficient set.
// [RULE11] Separate banks with own gain per mode.
// [RULE12] Out-of-range error clamps to -32 or 31.
// [RULE13] Saturated: slew DAC toward sense, 0.156 V/ms.
// [RULE14] Bank 0 ramp, 1 regulation, 2 light.
// [RULE15] Unsaturated again: stop slewing, resume tracking.
//
// Local design decisions: the register addresses and the strobed register port.
`timescale 1ns/10ps
`default_nettype none

module vse_setpoint_sense (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [31:0] rdata,
    input wire logic [9:0] vid_dac_code,
    input wire logic [11:0] sense_pos_input,
    input wire logic [11:0] sense_neg_input,
    input wire logic sw_period_start,
    input wire logic ramp_active,
    input wire logic [11:0] meas_current,
    output logic [9:0] ref_dac,
    output logic [5:0] error_code,
    output logic error_code_valid,
    output logic [1:0] active_bank,
    output logic [1:0] active_gain,
    output logic fault_suppress
);

    // -------------------------------------------------------------------
    // Configuration registers.
    // -------------------------------------------------------------------
    logic [1:0] op_reg;
    logic suppress_reg;
    logic dyn_reg;
    logic [9:0] vout_cmd_reg;
    logic [9:0] cal_ofs_reg;
    logic [7:0] scale_reg;
    logic [9:0] vout_max_reg;
    logic [9:0] margin_hi_reg;
    logic [9:0] margin_lo_reg;
    logic [11:0] sample_time_reg;
    logic [11:0] light_thr_reg;
    logic [1:0] gain_bank_reg [vse_pkg::NUM_BANKS];
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;

    // -------------------------------------------------------------------
    // Loop state.
    // -------------------------------------------------------------------
    logic [11:0] period_cnt_reg;
    logic sample_fire;
    logic [9:0] dac_reg;
    logic [9:0] target_code;
    logic signed [13:0] error_mv;
    logic signed [13:0] error_hold_reg;
    logic [5:0] q_code;
    logic q_valid;
    logic sat_reg;
    logic [8:0] slew_cnt_reg;
    logic [1:0] bank_reg;
    logic [1:0] bank_next;
    logic fault_sup_reg;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction

    function automatic logic is_sat(input logic [5:0] c);
        is_sat = (c == vse_pkg::CODE_MAX) || (c == vse_pkg::CODE_MIN);
    endfunction

    // -------------------------------------------------------------------
    // Register writes.
    // -------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            op_reg <= 2'h0;
            suppress_reg <= 1'b0;
            dyn_reg <= 1'b0;
        end else if (ce && wr_stb && hit(addr, vse_pkg::OFS_CTRL)) begin
            op_reg <= wdata[vse_pkg::CTRL_OP_LSB +: 2]; // [RULE3]
            suppress_reg <= wdata[vse_pkg::CTRL_SUPPRESS]; // [RULE4]
            dyn_reg <= wdata[vse_pkg::CTRL_DYN]; // [RULE1]
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            vout_cmd_reg <= vse_pkg::RST_VOUT_CMD;
            cal_ofs_reg <= 10'h000;
            scale_reg <= vse_pkg::RST_SCALE;
            vout_max_reg <= vse_pkg::RST_VOUT_MAX;
            margin_hi_reg <= vse_pkg::RST_VOUT_CMD;
            margin_lo_reg <= vse_pkg::RST_VOUT_CMD;
            sample_time_reg <= vse_pkg::RST_SAMPLE_TIME;
            light_thr_reg <= vse_pkg::RST_LIGHT_THR;
        end else if (ce && wr_stb) begin
            if (hit(addr, vse_pkg::OFS_VOUT_CMD)) begin
                vout_cmd_reg <= wdata[9:0];
            end
            if (hit(addr, vse_pkg::OFS_CAL_OFS)) begin
                cal_ofs_reg <= wdata[9:0];
            end
            if (hit(addr, vse_pkg::OFS_SCALE)) begin
                scale_reg <= wdata[7:0];
            end
            if (hit(addr, vse_pkg::OFS_VOUT_MAX)) begin
                vout_max_reg <= wdata[9:0];
            end
            if (hit(addr, vse_pkg::OFS_MARGIN_HI)) begin
                margin_hi_reg <= wdata[9:0];
            end
            if (hit(addr, vse_pkg::OFS_MARGIN_LO)) begin
                margin_lo_reg <= wdata[9:0];
            end
            if (hit(addr, vse_pkg::OFS_SAMPLE_TIME)) begin
                sample_time_reg <= wdata[11:0]; // [RULE5]
            end
            if (hit(addr, vse_pkg::OFS_LIGHT_THR)) begin
                light_thr_reg <= wdata[11:0];
            end
        end
    end

    // -------------------------------------------------------------------
    // Coefficient load: one gain per bank.
    // -------------------------------------------------------------------
    genvar gb;
    generate
        for (gb = 0; gb < vse_pkg::NUM_BANKS; gb++) begin : g_bank
            always_ff @(posedge ref_clk) begin
                if (!rst_n) begin
                    gain_bank_reg[gb] <= vse_pkg::RST_GAIN;
                end else if (ce && wr_stb && hit(addr, vse_pkg::OFS_COEF_LOAD)
                        && (wdata[vse_pkg::COEF_BANK_LSB +: 2] == 2'(gb))) begin
                    gain_bank_reg[gb] <= wdata[vse_pkg::COEF_GAIN_LSB +: 2]; // [RULE10] [RULE11]
                end
            end
        end
    endgenerate

    // -------------------------------------------------------------------
    // Register reads.
    // -------------------------------------------------------------------
    always_comb begin
        rdata_next = 32'h00000000;
        case (addr)
            vse_pkg::OFS_CTRL: rdata_next = {28'h0000000, dyn_reg, suppress_reg, op_reg};
            vse_pkg::OFS_VOUT_CMD: rdata_next = {22'h000000, vout_cmd_reg};
            vse_pkg::OFS_CAL_OFS: rdata_next = {22'h000000, cal_ofs_reg};
            vse_pkg::OFS_SCALE: rdata_next = {24'h000000, scale_reg};
            vse_pkg::OFS_VOUT_MAX: rdata_next = {22'h000000, vout_max_reg};
            vse_pkg::OFS_MARGIN_HI: rdata_next = {22'h000000, margin_hi_reg};
            vse_pkg::OFS_MARGIN_LO: rdata_next = {22'h000000, margin_lo_reg};
            vse_pkg::OFS_SAMPLE_TIME: rdata_next = {20'h00000, sample_time_reg};
            vse_pkg::OFS_COEF_LOAD: rdata_next = {26'h0000000, gain_bank_reg[2],
                                                  gain_bank_reg[1], gain_bank_reg[0]};
            vse_pkg::OFS_LIGHT_THR: rdata_next = {20'h00000, light_thr_reg};
            vse_pkg::OFS_STATUS: rdata_next = {11'h000, sat_reg, bank_reg, q_code, 2'b00,
                                               dac_reg};
            vse_pkg::OFS_ERROR: rdata_next = {{18{error_hold_reg[13]}}, error_hold_reg};
            default: rdata_next = 32'h00000000;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rdata_reg <= 32'h00000000;
        end else if (ce) begin
            rdata_reg <= rd_stb ? rdata_next : 32'h00000000;
        end
    end

    // -------------------------------------------------------------------
    // Set-point target.
    // -------------------------------------------------------------------
    vse_ref_target u_target (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .ce(ce),
        .dyn_voltage_select_cfg(dyn_reg), // [RULE1]
        .op_select(op_reg), // [RULE3]
        .vid_dac_code(vid_dac_code),
        .vout_command(vout_cmd_reg), // [RULE2]
        .vout_cal_offset(cal_ofs_reg),
        .vout_scale_loop(scale_reg),
        .vout_max(vout_max_reg),
        .margin_high(margin_hi_reg),
        .margin_low(margin_lo_reg),
        .target_code(target_code)
    );

    // -------------------------------------------------------------------
    // Sample timing within the switching period.
    // -------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            period_cnt_reg <= 12'h000;
        end else if (ce) begin
            period_cnt_reg <= sw_period_start ? 12'h000 : period_cnt_reg + 12'h001;
        end
    end

    assign sample_fire = !sw_period_start && (period_cnt_reg == sample_time_reg); // [RULE5]

    assign error_mv = 14'($signed({2'b00, sense_pos_input}) - $signed({2'b00, sense_neg_input}))
                      - $signed({4'h0, dac_reg}); // [RULE6]

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            error_hold_reg <= 14'h0000;
        end else if (ce && sample_fire) begin
            error_hold_reg <= error_mv;
        end
    end

    // -------------------------------------------------------------------
    // Bank selection and active gain.
    // -------------------------------------------------------------------
    always_comb begin
        if (ramp_active) begin
            bank_next = vse_pkg::VSE_BANK_RAMP; // [RULE14]
        end else if (meas_current < light_thr_reg) begin
            bank_next = vse_pkg::VSE_BANK_LIGHT;
        end else begin
            bank_next = vse_pkg::VSE_BANK_REG;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            bank_reg <= vse_pkg::VSE_BANK_REG;
        end else if (ce) begin
            bank_reg <= bank_next; // [RULE11]
        end
    end

    vse_error_quantizer u_quant (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .ce(ce),
        .sample(sample_fire),
        .error_mv(error_mv),
        .error_gain_code(gain_bank_reg[bank_reg]), // [RULE7] [RULE8] [RULE12]
        .code(q_code),
        .code_valid(q_valid)
    );

    // -------------------------------------------------------------------
    // Saturation slew of the reference DAC.
    // -------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            sat_reg <= 1'b0;
        end else if (ce && q_valid) begin
            sat_reg <= is_sat(q_code); // [RULE15]
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            slew_cnt_reg <= 9'h000;
        end else if (ce) begin
            if (!sat_reg || slew_cnt_reg == 9'(vse_pkg::SLEW_CYCLES - 1)) begin
                slew_cnt_reg <= 9'h000;
            end else begin
                slew_cnt_reg <= slew_cnt_reg + 9'h001;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            dac_reg <= 10'h000;
        end else if (ce) begin
            if (!sat_reg) begin
                dac_reg <= target_code; // [RULE15]
            end else if (slew_cnt_reg == 9'(vse_pkg::SLEW_CYCLES - 1)) begin
                if (q_code == vse_pkg::CODE_MAX && dac_reg != 10'h3ff) begin
                    dac_reg <= dac_reg + 10'h001; // [RULE13]
                end else if (q_code == vse_pkg::CODE_MIN && dac_reg != 10'h000) begin
                    dac_reg <= dac_reg - 10'h001; // [RULE13]
                end
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            fault_sup_reg <= 1'b0;
        end else if (ce) begin
            fault_sup_reg <= suppress_reg && (op_reg == vse_pkg::VSE_OP_MARGIN_LOW
                    || op_reg == vse_pkg::VSE_OP_MARGIN_HIGH); // [RULE4]
        end
    end

    assign rdata = rdata_reg;
    assign ref_dac = dac_reg;
    assign error_code = q_code;
    assign error_code_valid = q_valid;
    assign active_bank = bank_reg;
    assign active_gain = gain_bank_reg[bank_reg];
    assign fault_suppress = fault_sup_reg;

    // -------------------------------------------------------------------
    // Checks.
    // -------------------------------------------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_sat_step;
        sat_reg && ce && slew_cnt_reg == 9'(vse_pkg::SLEW_CYCLES - 1);
    endsequence

    chk_track_resume: assert property (ce && !sat_reg |=> dac_reg == $past(target_code)) // [RULE15]
        else $error("DAC did not follow target while unsaturated");
    chk_slew_step: assert property ((s_sat_step and q_code == vse_pkg::CODE_MAX // [RULE13]
            && dac_reg != 10'h3ff) |=> dac_reg == $past(dac_reg) + 10'h001)
        else $error("Slew step up missing");
    chk_slew_hold: assert property (sat_reg && ce && slew_cnt_reg != 9'(vse_pkg::SLEW_CYCLES - 1) // [RULE13]
            && $past(sat_reg) |=> $stable(dac_reg))
        else $error("DAC moved between slew steps");
    chk_sample_time: assert property (ce && sample_fire |=> q_valid // [RULE5]
            && error_hold_reg == $past(error_mv))
        else $error("Sample not at programmed time");
    chk_sat_clamp: assert property (ce && sample_fire && error_mv > 14'sd255 // [RULE12]
            && gain_bank_reg[bank_reg] == 2'h0 |=> q_valid && q_code == vse_pkg::CODE_MAX)
        else $error("Positive overrange not clamped");
    chk_gain_scale: assert property (ce && sample_fire && error_mv == 14'sd8 // [RULE7]
            && gain_bank_reg[bank_reg] == 2'h0 |=> q_code == 6'h01)
        else $error("Gain 1x step is not 8 mV");
    chk_bank_ramp: assert property (ce && ramp_active |=> bank_reg == vse_pkg::VSE_BANK_RAMP) // [RULE14]
        else $error("Ramp did not select bank 0");
    chk_fault_mask: assert property (ce ##1 ce |-> fault_sup_reg == $past(suppress_reg // [RULE4]
            && (op_reg == vse_pkg::VSE_OP_MARGIN_LOW
            || op_reg == vse_pkg::VSE_OP_MARGIN_HIGH)))
        else $error("Fault suppress mismatch");
    chk_gain_load: assert property (ce && wr_stb && hit(addr, vse_pkg::OFS_COEF_LOAD) // [RULE10]
            && wdata[5:4] == 2'h1 |=> gain_bank_reg[1] == $past(wdata[1:0]))
        else $error("Coefficient gain not loaded");

endmodule // vse_setpoint_sense

`default_nettype wire

// ==== test/vse_rail_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// -------------------------------------------------------------------
// Sensed rail and switching period source.
// -------------------------------------------------------------------
module vse_rail_model (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [11:0] rail_mv,
    input wire logic [7:0] cm,
    input wire logic [7:0] period,
    output logic [11:0] sense_pos_input,
    output logic [11:0] sense_neg_input,
    output logic sw_period_start
);
    logic [7:0] cnt_reg;
    always_ff @(posedge ref_clk) begin
        if (!rst_n || cnt_reg == period - 8'h01) begin
            cnt_reg <= 8'h00;
        end else begin
            cnt_reg <= cnt_reg + 8'h01;
        end
    end
    always_ff @(posedge ref_clk) begin
        sw_period_start <= rst_n && cnt_reg == 8'h00;
        sense_pos_input <= rail_mv + {4'h0, cm};
        sense_neg_input <= {4'h0, cm};
    end
endmodule // vse_rail_model
`default_nettype wire

// ==== test/tb.sv ====
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b, m) begin checks++; if ((a) !== (b)) begin n_errors++; $display("mismatch %0t %s", $time, m); end end
// -------------------------------------------------------------------
// Bench for the set-point and error sensing block.
// -------------------------------------------------------------------
module tb;
    logic ref_clk, rst_n, wr_stb, rd_stb, ramp_active, sw_period_start;
    logic error_code_valid, fault_suppress;
    logic [7:0] addr, cm;
    logic [31:0] wdata, rdata, rd_val;
    logic [9:0] vid_dac_code, ref_dac, r0, t;
    logic [11:0] sense_pos_input, sense_neg_input, meas_current, rail_mv;
    logic signed [11:0] d;
    logic [5:0] error_code;
    logic [1:0] active_bank, active_gain;
    int n_errors = 0, checks = 0, cycles = 0, n, e, s;

    vse_setpoint_sense dut (.ref_clk(ref_clk), .rst_n(rst_n), .ce(1'b1), .addr(addr),
        .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
        .vid_dac_code(vid_dac_code), .sense_pos_input(sense_pos_input),
        .sense_neg_input(sense_neg_input), .sw_period_start(sw_period_start),
        .ramp_active(ramp_active), .meas_current(meas_current), .ref_dac(ref_dac),
        .error_code(error_code), .error_code_valid(error_code_valid),
        .active_bank(active_bank), .active_gain(active_gain),
        .fault_suppress(fault_suppress));
    vse_rail_model rail (.ref_clk(ref_clk), .rst_n(rst_n), .rail_mv(rail_mv), .cm(cm),
        .period(8'h14), .sense_pos_input(sense_pos_input),
        .sense_neg_input(sense_neg_input), .sw_period_start(sw_period_start));

    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    task automatic conclude();
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            $display("mismatch %0t timeout", $time);
            conclude();
        end
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge ref_clk);
        addr <= a;
        wdata <= v;
        wr_stb <= 1'b1;
        @(posedge ref_clk);
        wr_stb <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge ref_clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge ref_clk);
        rd_stb <= 1'b0;
        #1 rd_val = rdata;
    endtask
    task automatic settle(input int k);
        repeat (k) @(posedge ref_clk);
        #1;
    endtask
    function automatic logic [9:0] nom(int v, int mx);
        if (v < 0) v = 0;
        v = (v * 255) >> 8;
        return 10'(v > mx ? mx : v);
    endfunction
    function automatic logic [5:0] qz(int v, int g);
        v = v >>> (3 - g);
        if (v > 31) v = 31;
        if (v < -32) v = -32;
        return 6'(v);
    endfunction

    initial begin
        {rst_n, wr_stb, rd_stb, ramp_active, addr, wdata} = '0;
        {vid_dac_code, rail_mv} = '0;
        meas_current = 12'h800;
        n = $urandom(32'h698e);
        cm = 8'($urandom_range(200, 0));
        repeat (12) @(posedge ref_clk);
        rst_n <= 1'b1;
        settle(1);
        `CHK(active_bank, 2'h1, "reset bank")
        `CHK(active_gain, 2'h2, "reset gain")
        rd(8'h20);
        `CHK(rd_val, 32'h2a, "bank gains")
        rd(8'h0c);
        `CHK(rd_val, 32'hff, "scale reset")
        rd(8'h3c);
        `CHK(rd_val, 32'h0, "unmapped")
        wr(8'h1c, 32'hfff);
        wr(8'h08, 32'h3);
        for (int i = 0; i < 4; i++) begin
            n = $urandom_range(900, 100);
            e = i == 3 ? 200 : 1023;
            rail_mv <= 12'(nom(n + 3, e));
            wr(8'h10, e);
            wr(8'h04, n);
            settle(60);
            `CHK(ref_dac, nom(n + 3, e), "nominal")
        end
        wr(8'h10, 32'h3ff);
        wr(8'h04, 32'd450);
        wr(8'h14, 32'd600);
        wr(8'h18, 32'd300);
        for (int op = 0; op < 8; op++) begin
            t = nom((op % 4 == 1 ? 300 : op % 4 == 2 ? 600 : 450) + 3, 1023);
            rail_mv <= 12'(t);
            wr(8'h00, op);
            settle(60);
            `CHK(ref_dac, t, "margin")
            `CHK(fault_suppress, 1'(op == 5 || op == 6), "suppress")
        end
        wr(8'h00, 32'h8);
        for (int i = 0; i < 3; i++) begin
            n = $urandom_range(1000, 50);
            vid_dac_code <= 10'(n);
            rail_mv <= 12'(n);
            settle(60);
            `CHK(ref_dac, 10'(n), "vid")
        end
        t = nom(453, 1023);
        rail_mv <= 12'(t);
        wr(8'h00, 32'h0);
        wr(8'h1c, 32'h5);
        for (int g = 0; g < 4; g++) begin
            e = int'($urandom_range(60, 0)) - 30;
            rail_mv <= 12'(t + e);
            wr(8'h20, 32'h10 | g);
            settle(60);
            `CHK(active_gain, 2'(g), "gain")
            `CHK(error_code, qz(e, g), "code")
            rd(8'h2c);
            `CHK(rd_val, 32'(e), "error word")
            rail_mv <= 12'(t - (31 <<< (3 - g)));
            settle(60);
            `CHK(error_code, 6'h21, "range edge")
        end
        for (int k = 0; k < 2; k++) begin
            s = k ? -100 : 100;
            rail_mv <= 12'(t + s);
            settle(40);
            `CHK(error_code, qz(s, 3), "saturate")
            r0 = ref_dac;
            rd(8'h28);
            `CHK(rd_val[20], 1'b1, "sat status")
            settle(600);
            d = k ? {2'b0, r0} - {2'b0, ref_dac} : {2'b0, ref_dac} - {2'b0, r0};
            `CHK(d >= 1 && d <= 3, 1'b1, "slew")
            rail_mv <= {2'b0, ref_dac};
            settle(60);
            `CHK(ref_dac, t, "resume")
        end
        wr(8'h20, 32'h01);
        wr(8'h20, 32'h20);
        wr(8'h20, 32'h12);
        wr(8'h24, 32'h100);
        for (int k = 0; k < 4; k++) begin
            ramp_active <= k[0];
            meas_current <= k[1] ? 12'h0ff : 12'h100;
            settle(4);
            `CHK(active_bank, k[0] ? 2'h0 : k[1] ? 2'h2 : 2'h1, "bank")
            `CHK(active_gain, k[0] ? 2'h1 : k[1] ? 2'h0 : 2'h2, "bank gain")
        end
        for (int k = 0; k < 2; k++) begin
            wr(8'h1c, k ? 32'h13 : 32'h12);
            settle(40);
            n = 0;
            repeat (200) begin
                @(posedge ref_clk);
                #1 n += error_code_valid;
            end
            `CHK(n, k ? 0 : 10, "samples")
        end
        conclude();
    end
endmodule // tb
`default_nettype wire
